/* File: include/adcrc_regs.vh */
// Constants of the conversion and readout controller
`ifndef ADCRC_REGS_VH
`define ADCRC_REGS_VH
`define ADCRC_CLK_MHZ          25
`define ADCRC_CONV_NS          1600
`define ADCRC_CONV_CYC         ((`ADCRC_CONV_NS * `ADCRC_CLK_MHZ) / 1000)
`define ADCRC_SCLK_DIV         8'h02
`define ADCRC_FMT_PAR          2'h0
`define ADCRC_FMT_GATED        2'h1
`define ADCRC_FMT_FREE         2'h2
`define ADCRC_SER_BITS         5'h10
`define ADCRC_DATA_RST         12'h000
`endif

/* File: verilog/adcrc_sync.v */
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
module adcrc_sync (
	input  wire clk,
	input  wire rst_b,
	input  wire rst_val,
	input  wire din,
	output reg  dout
);
	reg meta_q;
	// First flop feeds only the second
	always @(posedge clk) begin
		if (!rst_b) begin
			// Park at the pin's idle level so no false edge follows reset
			meta_q <= rst_val;
			dout   <= rst_val;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule // adcrc_sync

/* File: verilog/adcrc_ctrl.v */
// Conversion sequencing and result readout controller
`timescale 1ns/1ps
`include "adcrc_regs.vh"
module adcrc_ctrl (
	input  wire        CORE_CLK,
	input  wire        RST_B,
	input  wire        CONVERT_START_N,
	input  wire        CS_N,
	input  wire        RD_N,
	input  wire        UPPER_BYTE_SEL,
	input  wire [1:0]  FORMAT_SEL,
	input  wire [11:0] SAMPLE_CODE,
	output reg         STATUS_N,
	output reg         HOLD,
	output reg  [11:0] DATA_OUT,
	output reg  [11:0] DATA_OE_N,
	output reg         SERIAL_OUT,
	output reg         SERIAL_CLK,
	output reg         SERIAL_FRAME_N
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_SHIFT = 2'h2;
	localparam [31:0] CONV_CYC_W = `ADCRC_CONV_CYC;
	localparam [11:0] CONV_CYC = CONV_CYC_W[11:0];

	wire cvs_s;
	wire cs_s;
	wire rd_s;
	wire ub_s;
	reg  cvs_q;
	reg  cs_q;
	reg  read_mode_q;
	reg  [1:0]  state_q;
	reg  [11:0] cnt_q;
	reg  [11:0] result_q;
	reg  [15:0] shreg_q;
	reg  [4:0]  bits_q;
	reg  [7:0]  div_q;
	reg         sclk_q;
	reg         in_read_q;

	////////////////////////////////////////////////////////////////////////
	// Synchronise the four control pins; FORMAT_SEL and SAMPLE_CODE are used directly
	adcrc_sync u_cvs (.clk(CORE_CLK), .rst_b(RST_B), .rst_val(1'b1), .din(CONVERT_START_N), .dout(cvs_s));
	adcrc_sync u_cs  (.clk(CORE_CLK), .rst_b(RST_B), .rst_val(1'b1), .din(CS_N), .dout(cs_s));
	adcrc_sync u_rd  (.clk(CORE_CLK), .rst_b(RST_B), .rst_val(1'b1), .din(RD_N), .dout(rd_s));
	adcrc_sync u_ub  (.clk(CORE_CLK), .rst_b(RST_B), .rst_val(1'b0), .din(UPPER_BYTE_SEL), .dout(ub_s));

	wire cvs_rise = cvs_s & ~cvs_q;
	wire cs_fall  = ~cs_s & cs_q;
	wire serial   = (FORMAT_SEL != `ADCRC_FMT_PAR);
	wire rd_act   = ~cs_s & ~rd_s;
	wire start_e  = cvs_rise & cs_s & (state_q == ST_IDLE);
	wire start_r  = ~cvs_s & cs_fall & ~ub_s & (state_q == ST_IDLE);
	wire sclk_tick = (div_q == `ADCRC_SCLK_DIV - 8'h01);
	// Next shift clock level, so the pin and the data bit move on one edge
	wire sclk_next = sclk_tick ? ~sclk_q : sclk_q;
	// Last conversion cycle: a read already in progress sees the fresh code
	wire conv_done = (state_q == ST_CONV) && (cnt_q == CONV_CYC - 12'h001);
	wire [11:0] rd_word = conv_done ? SAMPLE_CODE : result_q;

	////////////////////////////////////////////////////////////////////////
	// Shift clock divider, free-running at a quarter of the core rate
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			div_q  <= 8'h00;
			sclk_q <= 1'b1;
		end else if (sclk_tick) begin
			div_q  <= 8'h00;
			sclk_q <= ~sclk_q;
		end else begin
			div_q  <= div_q + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion and serial sequencer
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			cvs_q <= 1'b1;
			cs_q <= 1'b1;
			read_mode_q <= 1'b0;
			state_q <= ST_IDLE;
			cnt_q <= 12'h000;
			result_q <= `ADCRC_DATA_RST;
			shreg_q <= 16'h0000;
			bits_q <= 5'h00;
			STATUS_N <= 1'b1;
			HOLD <= 1'b0;
			SERIAL_FRAME_N <= 1'b1;
			SERIAL_OUT <= 1'b0;
			in_read_q <= 1'b0;
		end else begin
			cvs_q <= cvs_s;
			cs_q <= cs_s;
			in_read_q <= rd_act;
			case (state_q)
			ST_IDLE: begin
				if (start_e || start_r) begin
					read_mode_q <= start_r;
					HOLD <= 1'b1;
					cnt_q <= 12'h000;
					state_q <= ST_CONV;
					if (start_r)
						STATUS_N <= 1'b0;
					else
						STATUS_N <= 1'b1;
					if (serial) begin
						SERIAL_FRAME_N <= 1'b0;
						SERIAL_OUT <= 1'b0;
						bits_q <= 5'h00;
					end
				end else if (rd_act && !in_read_q && !read_mode_q) begin
					STATUS_N <= 1'b1;
				end
			end
			ST_CONV: begin
				cnt_q <= cnt_q + 12'h001;
				if (cnt_q == CONV_CYC - 12'h001) begin
					result_q <= SAMPLE_CODE;
					shreg_q <= {4'h0, SAMPLE_CODE};
					HOLD <= 1'b0;
					if (serial) begin
						state_q <= ST_SHIFT;
						if (!read_mode_q)
							STATUS_N <= 1'b0;
					end else begin
						state_q <= ST_IDLE;
						STATUS_N <= read_mode_q ? 1'b1 : 1'b0;
					end
				end
			end
			ST_SHIFT: begin
				// Advance one bit on each rising shift clock edge
				if (sclk_tick && !sclk_q) begin
					if (bits_q == `ADCRC_SER_BITS) begin
						SERIAL_FRAME_N <= 1'b1;
						state_q <= ST_IDLE;
						if (read_mode_q)
							STATUS_N <= 1'b1;
					end else begin
						SERIAL_OUT <= shreg_q[15];
						shreg_q <= {shreg_q[14:0], 1'b0};
						bits_q <= bits_q + 5'h01;
					end
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift clock output: gated parks high, free runs always
	always @(posedge CORE_CLK) begin
		if (!RST_B)
			SERIAL_CLK <= 1'b1;
		else if (FORMAT_SEL == `ADCRC_FMT_FREE)
			SERIAL_CLK <= sclk_next;
		else if (FORMAT_SEL == `ADCRC_FMT_GATED && state_q == ST_SHIFT && (bits_q != 5'h00 || sclk_next))
			SERIAL_CLK <= sclk_next;
		else
			SERIAL_CLK <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Three-state data outputs
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			DATA_OUT  <= 12'h000;
			DATA_OE_N <= 12'hfff;
		end else if (rd_act && !start_e && !start_r && (state_q != ST_CONV || conv_done)) begin
			if (FORMAT_SEL == `ADCRC_FMT_PAR) begin
				DATA_OUT  <= rd_word;
				DATA_OE_N <= 12'h000;
			end else begin
				DATA_OUT  <= ub_s ? {4'h0, 4'h0, rd_word[11:8]} : {4'h0, rd_word[7:0]};
				DATA_OE_N <= 12'hf00;
			end
		end else begin
			DATA_OE_N <= 12'hfff;
		end
	end
endmodule // adcrc_ctrl

/* File: test/adcrc_chk.sv */
// Port checker of the conversion and readout controller
`timescale 1ns/1ps
module adcrc_chk (
	input wire logic	CORE_CLK,
	input wire logic	RST_B,
	input wire logic	CONVERT_START_N,
	input wire logic	CS_N,
	input wire logic [1:0]	FORMAT_SEL,
	input wire logic	STATUS_N,
	input wire logic	HOLD,
	input wire logic [11:0]	DATA_OE_N,
	input wire logic	SERIAL_OUT,
	input wire logic	SERIAL_CLK,
	input wire logic	SERIAL_FRAME_N
);
	// Core clock for all checks, quiet in reset
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////////////////////////
	// Output enables, conversion length, flags and shift link
	a_oe_idle: assert property (CS_N [*4] |-> &DATA_OE_N) else $error("driven while deselected");
	a_oe_conv: assert property (HOLD |-> &DATA_OE_N) else $error("driven in conversion");
	a_hold_len: assert property ($rose(HOLD) |-> HOLD [*8] ##32 HOLD ##1 !HOLD) else $error("hold length");
	a_done_low: assert property ($fell(HOLD) && CONVERT_START_N && CS_N && FORMAT_SEL == 2'h0
		|-> ##[0:2] !STATUS_N) else $error("no done flag");
	a_frame_fast: assert property ($rose(HOLD) && FORMAT_SEL != 2'h0 |-> ##[0:3] !SERIAL_FRAME_N)
		else $error("frame late");
	a_clk_park: assert property ((FORMAT_SEL == 2'h1 && SERIAL_FRAME_N) [*6] |-> SERIAL_CLK)
		else $error("clock not parked");
	a_bit_rise: assert property (!SERIAL_FRAME_N && !$past(SERIAL_FRAME_N) && $changed(SERIAL_OUT)
		|-> $rose(SERIAL_CLK)) else $error("bit off clock rise");
	a_hi_undriven: assert property (!DATA_OE_N[8] |-> FORMAT_SEL == 2'h0) else $error("upper lines driven");
endmodule // adcrc_chk

/* File: test/adcrc_rx.sv */
// Serial receiver model at the far end of the shift link
`timescale 1ns/1ps
module adcrc_rx (
	input wire logic	sclk,
	input wire logic	sdat,
	input wire logic	frame_n,
	output logic [15:0]	word_q
);
	logic	frame_late;
	// Late copy so a clock fall at the frame edge sees the old level
	assign #5 frame_late = frame_n;
	// One bit on each falling clock edge inside the frame
	always @(negedge sclk) begin
		if (!frame_late) word_q <= {word_q[14:0], sdat};
	end
endmodule // adcrc_rx

/* File: test/adcrc_ctrl_bench.sv */
// Self-checking bench of the conversion and readout controller
`timescale 1ns/1ps
module adcrc_ctrl_bench;
	logic		clk, rst_b, cst_n, cs_n, rd_n, ub, st_n, hold, sdo, sclk, frm_n;
	logic [1:0]	fmt;
	logic [11:0]	code, dout, oe_n;
	logic [15:0]	word;
	int		err_count, n_compared, cyc;
	adcrc_ctrl uut (.CORE_CLK(clk), .RST_B(rst_b), .CONVERT_START_N(cst_n), .CS_N(cs_n), .RD_N(rd_n),
		.UPPER_BYTE_SEL(ub), .FORMAT_SEL(fmt), .SAMPLE_CODE(code), .STATUS_N(st_n), .HOLD(hold),
		.DATA_OUT(dout), .DATA_OE_N(oe_n), .SERIAL_OUT(sdo), .SERIAL_CLK(sclk), .SERIAL_FRAME_N(frm_n));
	adcrc_rx rx (.sclk(sclk), .sdat(sdo), .frame_n(frm_n), .word_q(word));
	////////////////////////////////////////////////////////////
	// Compare and close
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Expected enables over driven data bits
	function logic [23:0] exp_rd(input logic [1:0] f, input logic u, input logic [11:0] c);
		if (f == 2'h0) return {12'h000, c};
		return u ? {16'hf000, 4'h0, c[11:8]} : {12'hf00, 4'h0, c[7:0]};
	endfunction
	task cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wt(input logic on_frame, input logic v);
		while ((on_frame ? frm_n : st_n) !== v) cy(1);
	endtask
	// One host read, then release
	task rd(input logic u);
		ub = u;
		cs_n = 1'b0;
		rd_n = 1'b0;
		cy(4);
		chk({oe_n, dout & ~oe_n}, exp_rd(fmt, u, code));
		cs_n = 1'b1;
		rd_n = 1'b1;
		cy(4);
		chk({11'h000, st_n, oe_n}, 24'h1fff);
	endtask
	// One conversion in either start mode
	task run(input logic rmode, input logic [1:0] f, input logic [11:0] c);
		fmt = f;
		code = c;
		cy(8);
		if (rmode) begin
			ub = 1'b0;
			cs_n = 1'b0;
			rd_n = 1'b0;
			wt(0, 0);
			chk({12'h000, oe_n}, 24'hfff);
			wt(0, 1);
		end else begin
			cst_n = 1'b1;
			wt(0, 0);
		end
		wt(1, 1);
		if (f != 2'h0) chk({8'h00, word}, {12'h000, c});
		if (rmode) begin
			cy(4);
			chk({oe_n, dout & ~oe_n}, exp_rd(f, 1'b0, c));
			cs_n = 1'b1;
			rd_n = 1'b1;
			cy(4);
		end else rd(1'b0);
		if (f != 2'h0) rd(1'b1);
		cst_n = 1'b0;
	endtask
	// Stand-alone: busy drives the strobe, result latched as busy rises
	task alone(input logic [11:0] c);
		fmt = 2'h0;
		code = c;
		ub = 1'b0;
		cy(8);
		cs_n = 1'b0;
		wt(0, 0);
		rd_n = 1'b0;
		wt(0, 1);
		rd_n = 1'b1;
		chk({oe_n, dout & ~oe_n}, {12'h000, c});
		cy(4);
		cs_n = 1'b1;
		cy(4);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			finish_test;
		end
	end
	// Reset, then both modes and all layouts with corner and random codes
	initial begin
		{rst_b, cst_n, ub, fmt, code} = '0;
		cs_n = 1'b1;
		rd_n = 1'b1;
		void'($urandom(21903));
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 6; j++) begin
				run(j[0], 2'(j / 2), (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom));
			end
			alone(12'($urandom));
		end
		finish_test;
	end
endmodule // adcrc_ctrl_bench
bind adcrc_ctrl adcrc_chk chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CONVERT_START_N(CONVERT_START_N),
	.CS_N(CS_N), .FORMAT_SEL(FORMAT_SEL), .STATUS_N(STATUS_N), .HOLD(HOLD), .DATA_OE_N(DATA_OE_N),
	.SERIAL_OUT(SERIAL_OUT), .SERIAL_CLK(SERIAL_CLK), .SERIAL_FRAME_N(SERIAL_FRAME_N));
